// ==== design/ebl_pkg.sv ====
package ebl_pkg;
   // Decoded level of the four-level role-select strap
   typedef enum logic [1:0] {
      EBL_LVL_LOW = 2'h0,
      EBL_LVL_RES = 2'h1,
      EBL_LVL_FLOAT = 2'h2,
      EBL_LVL_HIGH = 2'h3
   } ebl_level_type;

   localparam int EBL_EVENT_W = 8;
   localparam logic [7:0] EBL_MASK_RESET = 8'h00;
   localparam int EBL_SYNC_STAGES = 3;

   // Request towards the EEPROM reader engine
   typedef struct packed {
      logic start;
      logic bus_reset;
      logic regs_reset;
   } ebl_ctrl_type;

   // Answer from the EEPROM reader engine
   typedef struct packed {
      logic done;
      logic ok;
   } ebl_stat_type;
endpackage

// ==== design/ebl_sync.sv ====
`timescale 1ns/100ps
module ebl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else if (ce) begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change is accepted once the second and third stages agree
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dout <= INIT;
      end else if (ce) begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endmodule

// ==== design/ebl_boot_ctrl.sv ====
// How it works
// [R01] Floating role strap selects bus master; high selects slave; low levels reserved.
// [R02] In master role, load request going low starts one EEPROM read.
// [R03] Request held low after load finishes keeps normal operation, no reload.
// [R04] In slave role, low request holds bus machine and registers in reset.
// [R05] System keeps request high or floating in slave role for normal use.
// [R06] Master role: completion low only after a successful complete load.
// [R07] Slave role: completion output follows the request level.
// [R08] Interrupt pin pulls low while an enabled event is pending.
// [R09] Software mask chooses which events may raise the interrupt.
// [R10] Interrupt pin only pulls low, never drives high.
// [R11] Factory test inputs are ignored in normal operation.
// [R12] Master role: completion high from reset until the started load ends.
`timescale 1ns/100ps
module ebl_boot_ctrl #(
   parameter int EVENT_W = ebl_pkg::EBL_EVENT_W
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [1:0] bus_role_select,
   input wire logic load_req_n,
   input wire logic factory_test_in_a,
   input wire logic factory_test_in_b,
   input wire logic factory_test_in_c,
   input wire logic factory_test_in_d,
   input wire logic factory_test_in_e,
   input wire logic factory_test_in_f,
   input wire ebl_pkg::ebl_stat_type load_stat,
   output ebl_pkg::ebl_ctrl_type load_ctrl,
   output logic role_master,
   output logic role_reserved,
   output logic load_done_n,
   input wire logic [EVENT_W-1:0] irq_events,
   input wire logic [EVENT_W-1:0] irq_mask,
   output logic irq_n_o,
   output logic irq_n_oe
);
   typedef enum logic [1:0] {
      EBL_IDLE,
      EBL_LOADING,
      EBL_FINISHED
   } ebl_state_type;

   ebl_state_type state;
   ebl_state_type next_state;
   logic req_n_s;
   logic [1:0] role_s;
   logic role_valid;
   logic load_ok;
   logic req_low_d;
   logic req_fall;
   logic [2:0] settle_cnt;
   logic start_pulse;
   logic bus_hold;
   logic regs_hold;

   // Unknown role, or slave role with the request low, keeps the bus side in reset
   function automatic logic hold_in_reset(input logic valid, input logic master,
      input logic req_n);
      return !valid || (!master && !req_n);
   endfunction

   // Pin inputs cross into clk_sys; request idles high like its pull-up
   ebl_sync #(.W(1), .INIT(1'b1)) u_req_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .din(load_req_n),
      .dout(req_n_s)
   );

   ebl_sync #(.W(2), .INIT(2'h2)) u_role_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .din(bus_role_select),
      .dout(role_s)
   );

   // Synchroniser outputs keep their reset value for a few edges after release,
   // so the strap is read only once its level has reached the output
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         settle_cnt <= 3'h0;
      end else if (ce && !role_valid) begin
         settle_cnt <= settle_cnt + 3'h1;
      end
   end

   // Strap sampled once after reset release; later wiggles are ignored
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         role_valid <= 1'b0;
         role_master <= 1'b1;
         role_reserved <= 1'b0;
      end else if (ce && !role_valid && settle_cnt == 3'(ebl_pkg::EBL_SYNC_STAGES + 1)) begin
         role_valid <= 1'b1;
         // [R01] role decode
         role_master <= (role_s == ebl_pkg::EBL_LVL_FLOAT);
         role_reserved <= (role_s == ebl_pkg::EBL_LVL_LOW) ||
            (role_s == ebl_pkg::EBL_LVL_RES);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         req_low_d <= 1'b0;
      end else if (ce && role_valid) begin
         // Held until the role is known, so a request low since power-up still counts
         req_low_d <= !req_n_s;
      end
   end

   assign req_fall = !req_n_s && !req_low_d;

   // [R02] start on request
   always_comb begin
      next_state = state;
      case (state)
         EBL_IDLE: begin
            if (role_valid && role_master && req_fall) begin
               next_state = EBL_LOADING;
            end
         end
         EBL_LOADING: begin
            if (load_stat.done) begin
               next_state = EBL_FINISHED;
            end
         end
         // [R03] no reload while held
         EBL_FINISHED: next_state = EBL_FINISHED;
         default: next_state = EBL_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= EBL_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         load_ok <= 1'b0;
      end else if (ce && state == EBL_LOADING && load_stat.done) begin
         load_ok <= load_stat.ok;
      end
   end

   // Start is a one-cycle pulse on entry to loading
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         start_pulse <= 1'b0;
      end else if (ce) begin
         start_pulse <= (state == EBL_IDLE) && (next_state == EBL_LOADING);
      end
   end

   // [R04] slave-role hold in reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bus_hold <= 1'b1;
         regs_hold <= 1'b1;
      end else if (ce) begin
         bus_hold <= hold_in_reset(role_valid, role_master, req_n_s);
         regs_hold <= hold_in_reset(role_valid, role_master, req_n_s);
      end
   end

   // One driver for the whole struct; every field comes straight from a flop
   assign load_ctrl = '{start: start_pulse, bus_reset: bus_hold, regs_reset: regs_hold};

   // [R06] [R07] [R12] completion output
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         load_done_n <= 1'b1;
      end else if (ce) begin
         if (role_valid && !role_master) begin
            load_done_n <= req_n_s;
         end else begin
            load_done_n <= !((state == EBL_LOADING) && load_stat.done && load_stat.ok) &&
               !((state == EBL_FINISHED) && load_ok);
         end
      end
   end

   // [R08] [R09] [R10] open-drain interrupt, output level tied low
   assign irq_n_o = 1'b0;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_n_oe <= 1'b0;
      end else if (ce) begin
         irq_n_oe <= |(irq_events & irq_mask);
      end
   end

   // [R11] test pins are deliberately left unread in normal operation

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_start;
      ce && state == EBL_IDLE && next_state == EBL_LOADING;
   endsequence

   sequence s_good_end;
      ce && state == EBL_LOADING && load_stat.done && load_stat.ok;
   endsequence

   start_pulse_a: assert property (s_start |=> load_ctrl.start) // [R02]
      else $error("start not pulsed after request");
   start_role_a: assert property (load_ctrl.start |-> role_master) // [R01]
      else $error("load started outside master role");
   no_reload_a: assert property (state == EBL_FINISHED |-> !load_ctrl.start) // [R03]
      else $error("reload while finished");
   slave_hold_a: assert property (ce && role_valid && !role_master && !req_n_s
      |=> load_ctrl.bus_reset && load_ctrl.regs_reset) // [R04]
      else $error("slave reset hold missing");
   done_good_a: assert property (s_good_end |=> !load_done_n) // [R06]
      else $error("completion not low after good load");
   done_high_a: assert property (role_master && state != EBL_FINISHED
      && !$past(state == EBL_LOADING) |-> load_done_n) // [R12]
      else $error("completion low before load end");
   slave_follow_a: assert property (ce && role_valid && !role_master
      |=> load_done_n == $past(req_n_s)) // [R07]
      else $error("completion not following request");
   irq_pull_a: assert property (ce && |(irq_events & irq_mask) |=> irq_n_oe) // [R08]
      else $error("interrupt not pulled");
   irq_mask_a: assert property (ce && !(|(irq_events & irq_mask)) |=> !irq_n_oe) // [R09]
      else $error("masked event pulled interrupt");
   irq_od_a: assert property (irq_n_o == 1'b0) // [R10]
      else $error("interrupt drives high");
   role_keep_a: assert property (role_valid |=> $stable(role_master) && $stable(role_reserved)) // [R01]
      else $error("role changed after capture");
endmodule

// ==== dv/ebl_eeprom_model.sv ====
`timescale 1ns/100ps
module ebl_eeprom_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire ebl_pkg::ebl_ctrl_type ctrl,
   input wire logic pass,
   output ebl_pkg::ebl_stat_type stat
);
   int cnt;
   // read ends a fixed span after start
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         stat <= '0;
      end else begin
         stat <= '0;
         if (ctrl.start) begin
            cnt <= 12;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               stat <= {1'b1, pass};
            end
         end
      end
   end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 0;
   logic rstn = 0;
   logic ce = 1;
   logic [1:0] role = 2'h2;
   logic req_n = 1;
   logic [5:0] ft = '0;
   logic [7:0] ev = '0;
   logic [7:0] mask = '0;
   logic pass = 1;
   ebl_pkg::ebl_ctrl_type ctrl;
   ebl_pkg::ebl_stat_type stat;
   logic mst, rsv, done_n, irq_o, irq_oe;
   // board pull-up: the shared net only goes low while the pin is enabled
   wire logic irq_net = irq_oe ? irq_o : 1'b1;
   int n_fail = 0;
   int check_count = 0;
   int n_start = 0;
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (ctrl.start === 1'b1) n_start++;
   ebl_boot_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .bus_role_select(role),
      .load_req_n(req_n), .factory_test_in_a(ft[0]), .factory_test_in_b(ft[1]),
      .factory_test_in_c(ft[2]), .factory_test_in_d(ft[3]), .factory_test_in_e(ft[4]),
      .factory_test_in_f(ft[5]), .load_stat(stat), .load_ctrl(ctrl), .role_master(mst),
      .role_reserved(rsv), .load_done_n(done_n), .irq_events(ev), .irq_mask(mask),
      .irq_n_o(irq_o), .irq_n_oe(irq_oe));
   ebl_eeprom_model eeprom (.clk_sys(clk_sys), .rstn(rstn), .ctrl(ctrl), .pass(pass),
      .stat(stat));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic [1:0] lvl);
      @(negedge clk_sys);
      role = lvl;
      rstn = 0;
      repeat (16) @(negedge clk_sys);
      rstn = 1;
      repeat (8) @(negedge clk_sys);
      n_start = 0;
   endtask
   task automatic t_master(input logic ok);
      int n;
      pass = ok;
      do_reset(2'h2);
      chk(8'(mst), 8'h01);
      chk(8'(done_n), 8'h01);
      chk(8'({ctrl.bus_reset, ctrl.regs_reset}), 8'h00);
      // test pins wiggle during the failing run and must change nothing
      ft = ok ? 6'h00 : 6'h3f;
      req_n = 0;
      for (n = 0; n < 20 && ctrl.start !== 1'b1; n++) @(negedge clk_sys);
      chk(8'(ctrl.start), 8'h01);
      repeat (5) @(negedge clk_sys);
      chk(8'(done_n), 8'h01);
      repeat (40) @(negedge clk_sys);
      chk(8'(n_start), 8'h01);
      chk(8'(done_n), 8'(!ok));
      // A second fall after the load has ended must not start another one
      req_n = 1;
      repeat (6) @(negedge clk_sys);
      req_n = 0;
      repeat (8) @(negedge clk_sys);
      chk(8'(n_start), 8'h01);
      chk(8'(done_n), 8'(!ok));
      req_n = 1;
      $display("master load test done, ok=%0d", ok);
   endtask
   task automatic t_slave();
      int i;
      do_reset(2'h3);
      chk(8'(mst), 8'h00);
      for (i = 0; i < 2; i++) begin
         // request returns high for normal slave operation
         req_n = i[0];
         repeat (8) @(negedge clk_sys);
         chk(8'(done_n), 8'(i));
         chk(8'({ctrl.bus_reset, ctrl.regs_reset}), i ? 8'h00 : 8'h03);
      end
      chk(8'(n_start), 8'h00);
      do_reset(2'h1);
      chk(8'({mst, rsv}), 8'h01);
      // A reserved strap behaves as slave: a low request never loads
      req_n = 0;
      repeat (8) @(negedge clk_sys);
      chk(8'(n_start), 8'h00);
      chk(8'(done_n), 8'h00);
      req_n = 1;
      repeat (8) @(negedge clk_sys);
      $display("slave role test done");
   endtask
   task automatic t_irq();
      ft = 6'h3f;
      ev = 8'h05;
      repeat (3) @(negedge clk_sys);
      chk(8'(irq_net), 8'h01);
      mask = 8'h0a;
      repeat (3) @(negedge clk_sys);
      chk(8'(irq_net), 8'h01);
      mask = 8'h04;
      repeat (3) @(negedge clk_sys);
      chk(8'({irq_net, irq_o}), 8'h00);
      // A low clock enable freezes the pulled pin even after the event goes
      ce = 0;
      ev = 8'h00;
      repeat (3) @(negedge clk_sys);
      chk(8'(irq_net), 8'h00);
      ce = 1;
      repeat (3) @(negedge clk_sys);
      chk(8'(irq_net), 8'h01);
      chk(8'(n_start), 8'h00);
      $display("interrupt test done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      t_master(1);
      t_master(0);
      t_slave();
      t_irq();
      close_out();
   end
   // The tests need about 280 cycles; the limit leaves a wide margin
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      close_out();
   end
endmodule
